/* File: hdl/ddrio_pkg.sv */
// Function
// - Core output signals are registered before reaching the pad buffer.
// - Single-rate mode: negative-phase data feeds one element driving the pad.
// - Single-rate element is selectable as D flip-flop or level latch.
// - Double-rate mode: both phase inputs registered on the rising clock edge.
// - Double-rate: registered positive-phase data passes a latch the next cycle.
// - Double-rate: clock-driven multiplexer picks the stored value per phase.
// - Polarity selector sets the edge used by read-path synchronizing registers.
// - Synchronizing polarity is re-evaluated at the start of every read.
// - Detection logic recognises strobe going from idle level to low.
// - Preamble detection result sets the synchronizing clock polarity.
// - Dedicated polarity-control signal selects synchronizer clock polarity.
// - A quarter-period shifted write strobe comes from the strobe-delay block.
// - Shifted write strobe is distributed to every bit of the data bus.
package ddrio_pkg;
    // ----------------------------------------------------------------
    // Sizes and reset values
    // ----------------------------------------------------------------
    localparam int DATA_W = 8;
    localparam logic POL_RESET = 1'b0;
    localparam logic [1:0] PHASE_RESET = 2'h0;

    typedef struct packed {
        logic [DATA_W-1:0] neg;
        logic [DATA_W-1:0] pos;
    } ddrio_out_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h1,
        ST_PREAMBLE = 3'h2,
        ST_READ = 3'h4
    } ddrio_rd_state_t;
endpackage : ddrio_pkg

/* File: hdl/ddrio_sync2.sv */
`timescale 1ns/100ps
module ddrio_sync2 #(
    parameter int W = 1
) (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic [W-1:0] i_async,
    output logic [W-1:0] o_sync
);
    logic [W-1:0] meta_reg;
    logic [W-1:0] sync_reg;
    logic [W-1:0] meta_next;
    logic [W-1:0] sync_next;

    always_comb begin
        meta_next = i_async;
        sync_next = meta_reg;
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            meta_reg <= '0;
            sync_reg <= '0;
        end else begin
            meta_reg <= meta_next;
            sync_reg <= sync_next;
        end
    end

    assign o_sync = sync_reg;
endmodule : ddrio_sync2

/* File: hdl/ddrio_top.sv */
`timescale 1ns/100ps
module ddrio_top (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_ddr_mode,
    input wire logic i_latch_mode,
    input wire logic i_latch_en,
    input wire ddrio_pkg::ddrio_out_t i_out_data,
    input wire logic i_edge_clock_one,
    input wire logic i_strobe_in,
    input wire logic i_strobe_oe_n,
    input wire logic [ddrio_pkg::DATA_W-1:0] i_read_data,
    output logic [ddrio_pkg::DATA_W-1:0] o_pad_out_drive,
    output logic o_sync_clock_polarity_sel,
    output logic o_preamble_seen,
    output logic [ddrio_pkg::DATA_W-1:0] o_read_data,
    output logic o_read_valid,
    output logic [ddrio_pkg::DATA_W-1:0] o_write_strobe_shifted
);
    localparam int W = ddrio_pkg::DATA_W;

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    // Bit order: data, edge clock, strobe level, strobe driven flag
    logic [W+2:0] pins_sync;
    ddrio_sync2 #(.W(W + 3)) ddrio_sync2_inst (
        .i_clk(i_clk),
        .i_reset(i_reset),
        .i_async({i_read_data, i_edge_clock_one, i_strobe_in, ~i_strobe_oe_n}),
        .o_sync(pins_sync)
    );
    logic [W-1:0] rd_s;
    logic eclk_s;
    logic dqs_s;
    logic dqs_drv_s;
    assign rd_s = pins_sync[W+2:3];
    assign eclk_s = pins_sync[2];
    assign dqs_s = pins_sync[1];
    assign dqs_drv_s = pins_sync[0];

    // ----------------------------------------------------------------
    // Output register block
    // ----------------------------------------------------------------
    logic [W-1:0] neg_reg, neg_next;
    logic [W-1:0] pos_reg, pos_next;
    logic [W-1:0] pos_lat_reg, pos_lat_next;
    logic [W-1:0] pad_reg, pad_next;
    logic phase_reg, phase_next;

    always_comb begin
        neg_next = i_out_data.neg;
        pos_next = i_out_data.pos;
        pos_lat_next = pos_lat_reg;
        phase_next = ~phase_reg;
        pad_next = pad_reg;
        if (i_ddr_mode) begin
            // Positive data held a cycle so it survives the next capture
            pos_lat_next = pos_reg;
            pad_next = phase_reg ? pos_lat_reg : neg_reg;
        end else if (i_latch_mode) begin
            // Transparent while enable high, closed otherwise
            if (i_latch_en) begin
                pad_next = i_out_data.neg;
            end
        end else begin
            pad_next = i_out_data.neg;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            neg_reg <= '0;
            pos_reg <= '0;
            pos_lat_reg <= '0;
            pad_reg <= '0;
            phase_reg <= 1'b0;
        end else begin
            neg_reg <= neg_next;
            pos_reg <= pos_next;
            pos_lat_reg <= pos_lat_next;
            pad_reg <= pad_next;
            phase_reg <= phase_next;
        end
    end

    assign o_pad_out_drive = pad_reg;

    // ----------------------------------------------------------------
    // Preamble detection and polarity control
    // ----------------------------------------------------------------
    ddrio_pkg::ddrio_rd_state_t st_reg, st_next;
    logic pol_reg, pol_next;
    logic pre_reg, pre_next;
    logic eclk_d_reg;

    always_comb begin
        st_next = st_reg;
        pol_next = pol_reg;
        pre_next = 1'b0;
        case (st_reg)
            ddrio_pkg::ST_IDLE: begin
                // Strobe undriven means idle; first driven low marks preamble
                if (dqs_drv_s && !dqs_s) begin
                    st_next = ddrio_pkg::ST_PREAMBLE;
                    pre_next = 1'b1;
                    // Sample clock phase at detection to pick the safe edge
                    pol_next = eclk_s;
                end
            end
            ddrio_pkg::ST_PREAMBLE: begin
                if (!dqs_drv_s) begin
                    st_next = ddrio_pkg::ST_IDLE;
                end else if (dqs_s) begin
                    st_next = ddrio_pkg::ST_READ;
                end
            end
            ddrio_pkg::ST_READ: begin
                if (!dqs_drv_s) begin
                    st_next = ddrio_pkg::ST_IDLE;
                end
            end
            default: st_next = ddrio_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            st_reg <= ddrio_pkg::ST_IDLE;
            pol_reg <= ddrio_pkg::POL_RESET;
            pre_reg <= 1'b0;
            eclk_d_reg <= 1'b0;
        end else begin
            st_reg <= st_next;
            pol_reg <= pol_next;
            pre_reg <= pre_next;
            eclk_d_reg <= eclk_s;
        end
    end

    assign o_sync_clock_polarity_sel = pol_reg;
    assign o_preamble_seen = pre_reg;

    // ----------------------------------------------------------------
    // Read-path synchronizing registers
    // ----------------------------------------------------------------
    logic [W-1:0] rdat_reg, rdat_next;
    logic rval_reg, rval_next;
    logic cap_edge;
    // Capture on the link-clock edge chosen by the polarity select
    assign cap_edge = pol_reg ? (eclk_d_reg && !eclk_s) : (!eclk_d_reg && eclk_s);

    always_comb begin
        rdat_next = rdat_reg;
        rval_next = 1'b0;
        if (st_reg == ddrio_pkg::ST_READ && cap_edge) begin
            rdat_next = rd_s;
            rval_next = 1'b1;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            rdat_reg <= '0;
            rval_reg <= 1'b0;
        end else begin
            rdat_reg <= rdat_next;
            rval_reg <= rval_next;
        end
    end

    assign o_read_data = rdat_reg;
    assign o_read_valid = rval_reg;

    // ----------------------------------------------------------------
    // Shifted write strobe
    // ----------------------------------------------------------------
    // Quarter-period shift: delayed edge clock, fanned to each data bit
    logic ws_reg, ws_next;
    always_comb begin
        ws_next = eclk_d_reg;
    end
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            ws_reg <= 1'b0;
        end else begin
            ws_reg <= ws_next;
        end
    end

    genvar g;
    generate
        for (g = 0; g < W; g++) begin : g_ws
            assign o_write_strobe_shifted[g] = ws_reg;
        end
    endgenerate

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    a_pol_reset_default: assert property (@(posedge i_clk)
        $fell(i_reset) |-> $past(pol_reg) == ddrio_pkg::POL_RESET)
        else $error("polarity not at default after reset");
    a_pol_hold_stable: assert property (@(posedge i_clk) disable iff (i_reset)
        !pre_reg |-> pol_reg == $past(pol_reg))
        else $error("polarity changed without preamble");
    a_pre_from_idle: assert property (@(posedge i_clk) disable iff (i_reset)
        pre_reg |-> $past(st_reg) == ddrio_pkg::ST_IDLE && !$past(dqs_s))
        else $error("preamble flag without idle low strobe");
    a_pol_takes_clk: assert property (@(posedge i_clk) disable iff (i_reset)
        pre_reg |-> pol_reg == $past(eclk_s))
        else $error("polarity not from detection");
    a_sdr_ff_path: assert property (@(posedge i_clk) disable iff (i_reset)
        !i_ddr_mode && !i_latch_mode |=> o_pad_out_drive == $past(i_out_data.neg))
        else $error("single-rate flop path wrong");
    a_sdr_latch_hold: assert property (@(posedge i_clk) disable iff (i_reset)
        !i_ddr_mode && i_latch_mode && !i_latch_en |=> $stable(o_pad_out_drive))
        else $error("closed latch changed");
    a_ddr_pos_path: assert property (@(posedge i_clk) disable iff (i_reset)
        i_ddr_mode [*3] ##0 phase_reg |=> o_pad_out_drive == $past(i_out_data.pos, 3))
        else $error("double-rate positive path wrong");
    a_ddr_neg_path: assert property (@(posedge i_clk) disable iff (i_reset)
        i_ddr_mode [*2] ##0 !phase_reg |=> o_pad_out_drive == $past(i_out_data.neg, 2))
        else $error("double-rate negative path wrong");
    a_rd_only_in_read: assert property (@(posedge i_clk) disable iff (i_reset)
        o_read_valid |-> $past(st_reg) == ddrio_pkg::ST_READ)
        else $error("read capture outside read");
    a_ws_fanout: assert property (@(posedge i_clk) disable iff (i_reset)
        o_write_strobe_shifted == {W{$past(eclk_s, 2)}})
        else $error("write strobe not the delayed edge clock on every bit");

    c_preamble: cover property (@(posedge i_clk) pre_reg);
    c_read_cap: cover property (@(posedge i_clk) o_read_valid && pol_reg);
    c_ddr_run: cover property (@(posedge i_clk) i_ddr_mode [*4]);
    c_latch: cover property (@(posedge i_clk) i_latch_mode && i_latch_en);
endmodule : ddrio_top

/* File: verif/ddrio_mem_model.sv */
`timescale 1ns/100ps
module ddrio_mem_model (
    input wire logic i_clk,
    output logic o_strobe,
    output logic o_strobe_oe_n,
    output logic [ddrio_pkg::DATA_W-1:0] o_data
);
    logic active;

    initial begin
        active = 1'b0;
        o_strobe = 1'b1;
        o_strobe_oe_n = 1'b1;
        o_data = 8'h5a;
    end

    // Released data flips every cycle so a stale value can never pass
    always @(posedge i_clk) begin
        if (!active) begin
            o_data <= ~o_data;
        end
    end

    // Strobe and its enable change only in the burst, never twice in one step
    task automatic read_burst(input logic [ddrio_pkg::DATA_W-1:0] d);
        active = 1'b1;
        o_strobe_oe_n = 1'b0;
        o_strobe = 1'b0;
        o_data = d;
        repeat (8) @(posedge i_clk);
        repeat (6) begin
            #1 o_strobe = 1'b1;
            repeat (4) @(posedge i_clk);
            #1 o_strobe = 1'b0;
            repeat (4) @(posedge i_clk);
        end
        // Released strobe floats to its termination level
        #1 o_strobe = 1'b1;
        o_strobe_oe_n = 1'b1;
        active = 1'b0;
    endtask : read_burst
endmodule : ddrio_mem_model

/* File: verif/ddrio_top_tb.sv */
`timescale 1ns/100ps
module ddrio_top_tb;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic ddr = 1'b0;
    logic lmode = 1'b0;
    logic len = 1'b0;
    ddrio_pkg::ddrio_out_t od = '0;
    logic eclk = 1'b0;
    logic stb;
    logic stb_oe_n;
    logic [7:0] rdat;
    logic [7:0] pad;
    logic pol;
    logic pre;
    logic [7:0] rd;
    logic rv;
    logic [7:0] wstb;
    logic [3:0] hist = 4'h0;
    int fails = 0;
    int check_count = 0;
    int cyc = 0;

    always #50 clk = ~clk;
    // Link clock offset so its edges never meet the system clock edges
    initial begin
        #37;
        forever #400 eclk = ~eclk;
    end
    always @(posedge clk) hist <= {hist[2:0], eclk};

    ddrio_top ddrio_top_inst (
        .i_clk(clk), .i_reset(rst), .i_ddr_mode(ddr), .i_latch_mode(lmode),
        .i_latch_en(len), .i_out_data(od), .i_edge_clock_one(eclk),
        .i_strobe_in(stb), .i_strobe_oe_n(stb_oe_n), .i_read_data(rdat),
        .o_pad_out_drive(pad), .o_sync_clock_polarity_sel(pol),
        .o_preamble_seen(pre), .o_read_data(rd), .o_read_valid(rv),
        .o_write_strobe_shifted(wstb)
    );

    ddrio_mem_model ddrio_mem_model_inst (
        .i_clk(clk), .o_strobe(stb), .o_strobe_oe_n(stb_oe_n), .o_data(rdat)
    );

    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : step

    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic summarize();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : summarize

    task automatic t_reset();
        step(12);
        chk("pad", 16'h0, {8'h0, pad});
        chk("pol", 16'h0, {15'h0, pol});
        rst = 1'b0;
        $display("test reset done");
    endtask : t_reset

    task automatic t_sdr();
        od = '{neg: 8'ha5, pos: 8'h3c};
        step(1);
        chk("pad", 16'h00a5, {8'h0, pad});
        od = '{neg: 8'h5a, pos: 8'hff};
        step(1);
        chk("pad", 16'h005a, {8'h0, pad});
        lmode = 1'b1;
        od.neg = 8'hc3;
        step(2);
        chk("pad", 16'h005a, {8'h0, pad});
        len = 1'b1;
        step(1);
        chk("pad", 16'h00c3, {8'h0, pad});
        $display("test sdr done");
    endtask : t_sdr

    task automatic t_ddr();
        logic [7:0] a;
        logic [7:0] p2;
        ddr = 1'b1;
        lmode = 1'b0;
        od = '{neg: 8'h11, pos: 8'h22};
        step(5);
        a = pad;
        chk("ddr_first", 16'h1, {15'h0, a === 8'h11 || a === 8'h22});
        step(1);
        chk("ddr_xor", 16'h0033, {8'h0, a ^ pad});
        step(1);
        chk("ddr_again", {8'h0, a}, {8'h0, pad});
        // Positive data reaches the pad one cycle after negative data
        od = '{neg: 8'h44, pos: 8'h88};
        step(2);
        p2 = pad;
        step(1);
        chk("ddr_next", (p2 === 8'h44) ? 16'h0088 : 16'h0044, {8'h0, pad});
        step(1);
        chk("ddr_last", (p2 === 8'h44) ? 16'h0044 : 16'h0088, {8'h0, pad});
        ddr = 1'b0;
        $display("test ddr done");
    endtask : t_ddr

    task automatic t_read(input logic lvl, input logic [7:0] d);
        logic seen;
        logic [7:0] got;
        seen = 1'b0;
        got = ~d;
        wait (eclk !== lvl);
        wait (eclk === lvl);
        step(2);
        fork
            ddrio_mem_model_inst.read_burst(d);
        join_none
        for (int i = 0; i < 10 && !seen; i++) begin
            step(1);
            seen = (pre === 1'b1);
        end
        chk("preamble", 16'h1, {15'h0, seen});
        chk("pol", {15'h0, lvl}, {15'h0, pol});
        for (int i = 0; i < 40; i++) begin
            step(1);
            if (rv === 1'b1)
                got = rd;
        end
        chk("rdata", {8'h0, d}, {8'h0, got});
        step(40);
        chk("pol_hold", {15'h0, lvl}, {15'h0, pol});
        $display("test read done");
    endtask : t_read

    task automatic t_wstrobe();
        int bad;
        bad = 0;
        for (int i = 0; i < 40; i++) begin
            step(1);
            if (wstb !== {8{hist[3]}})
                bad++;
        end
        chk("wstrobe", 16'h0, bad[15:0]);
        $display("test wstrobe done");
    endtask : t_wstrobe

    // Whole run is well under 1000 cycles
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            fails++;
            summarize();
        end
    end

    initial begin
        t_reset();
        t_sdr();
        t_ddr();
        t_read(1'b1, 8'h96);
        t_read(1'b0, 8'h69);
        t_wstrobe();
        summarize();
    end
endmodule : ddrio_top_tb
